// File: serial_boot_consts.svh
// Constants for the serial boot download engine: field sizes, passwords and bit positions.
`ifndef SERIAL_BOOT_CONSTS_SVH
`define SERIAL_BOOT_CONSTS_SVH

`define PASSWORD_LAST_BYTE 3'h7
`define ADDRESS_LAST_BYTE 3'h3
`define SIZE_LAST_BYTE 3'h3
`define WORD_LAST_BYTE 3'h7
`define WORD_STEP 32'h0000_0008
`define PUBLIC_PASSWORD 64'hFEED_FACE_CAFE_BEEF
`define HALF_ALL_ZERO 16'h0000
`define HALF_ALL_ONES 16'hFFFF
`define ENC_FLAG_BIT 31
`define FRAME_EMPTY 4'h0

`endif

// File: serial_boot_pkg.sv
// Types shared by the serial boot download engine.
package serial_boot_pkg;

    // One-hot download sequence states.
    typedef enum logic [7:0] {
        ST_PASSWORD = 8'h01,
        ST_CHECK = 8'h02,
        ST_ADDRESS = 8'h04,
        ST_SIZE = 8'h08,
        ST_DATA = 8'h10,
        ST_DONE = 8'h20,
        ST_LOCKED = 8'h40
    } state_type;

endpackage

// File: sram_word_if.sv
// Carrier for one packed double word travelling from the downloader to the SRAM write port.
`timescale 1ns/1ps
`default_nettype none

interface sram_word_if;
    logic valid;
    logic ready;
    logic [31:0] addr;
    logic [63:0] data;

    modport source (output valid, output addr, output data, input ready);
    modport sink (input valid, input addr, input data, output ready);
endinterface

`default_nettype wire

// File: sram_write_port.sv
// SRAM write port: registers one double word and attaches its ECC check bits.
`timescale 1ns/1ps
`default_nettype none

module sram_write_port (
    input wire logic clk_sys,
    input wire logic reset_n,
    sram_word_if.sink word_in,
    output logic sram_wr_valid,
    input wire logic sram_wr_ready,
    output logic [31:0] sram_wr_addr,
    output logic [63:0] sram_wr_data,
    output logic [7:0] sram_wr_ecc
);

    logic valid_reg, valid_next;
    logic [31:0] addr_reg, addr_next;
    logic [63:0] data_reg, data_next;
    logic [7:0] ecc_reg, ecc_next;

    // Check bits: six positional parities, one overall and one over even bits.
    function automatic logic [7:0] ecc_bits(input logic [63:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int j = 0; j < 64; j++) begin
            for (int i = 0; i < 6; i++) begin
                if (j[i]) begin
                    c[i] = c[i] ^ d[j];
                end
            end
            c[6] = c[6] ^ d[j];
            if (!j[0]) begin
                c[7] = c[7] ^ d[j];
            end
        end
        return c;
    endfunction

    // Accept a word whenever the holding register is empty or being drained.
    assign word_in.ready = !valid_reg || sram_wr_ready;

    // Every write carries fresh check bits, so the target needs no prior init.
    always_comb begin
        valid_next = valid_reg;
        addr_next = addr_reg;
        data_next = data_reg;
        ecc_next = ecc_reg;
        if (valid_reg && sram_wr_ready) begin
            valid_next = 1'b0;
        end
        if (word_in.valid && word_in.ready) begin
            valid_next = 1'b1;
            addr_next = word_in.addr;
            data_next = word_in.data;
            ecc_next = ecc_bits(word_in.data);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            valid_reg <= 1'b0;
            addr_reg <= 32'h0000_0000;
            data_reg <= 64'h0000_0000_0000_0000;
            ecc_reg <= 8'h00;
        end else begin
            valid_reg <= valid_next;
            addr_reg <= addr_next;
            data_reg <= data_next;
            ecc_reg <= ecc_next;
        end
    end

    assign sram_wr_valid = valid_reg;
    assign sram_wr_addr = addr_reg;
    assign sram_wr_data = data_reg;
    assign sram_wr_ecc = ecc_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    ecc_hold_a: assert property (
        sram_wr_valid && !sram_wr_ready |=> $stable(sram_wr_ecc) && $stable(sram_wr_data))
        else $error("SRAM word changed while stalled");

endmodule

`default_nettype wire

// File: serial_boot_download.sv
// Serial boot download engine: password gate, header parse, echo and 64-bit SRAM packing.
`timescale 1ns/1ps
`default_nettype none
`include "serial_boot_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Fields arrive as password, address, size word with flag, then the image.
// - Every byte taken over the serial line is sent straight back, except in the locked state.
// - Every data frame taken over CAN is sent straight back, except in the locked state.
// - Payload bytes are packed eight at a time into one 64-bit write.
// - Each 64-bit write carries freshly computed ECC check bits.
// - Download needs a valid password, flash or public as selected.
// - Public selection compares against the fixed public constant.
// - A flash password with an all-zero or all-one halfword is invalid.
// - Password bytes or frames are echoed whether or not they match.
// - Acceptance shows only as the address echo; rejection stays silent.
// - After rejection nothing is accepted until watchdog timeout or reset.
// - The received password copy is wiped after the comparison.
// - CAN buffer zero is held during a CAN download and released at handover.
// - Watchdog always runs; refreshed at acceptance and after every write.
module serial_boot_download
    import serial_boot_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic boot_over_can,
    input wire logic public_password_select,
    input wire logic [63:0] flash_password,
    input wire logic wdt_timeout,
    input wire logic uart_rx_valid,
    input wire logic [7:0] uart_rx_data,
    output logic uart_tx_valid,
    output logic [7:0] uart_tx_data,
    input wire logic uart_tx_ready,
    input wire logic can_rx_valid,
    input wire logic [63:0] can_rx_data,
    input wire logic [3:0] can_rx_len,
    output logic can_tx_valid,
    output logic [63:0] can_tx_data,
    output logic [3:0] can_tx_len,
    input wire logic can_tx_ready,
    output logic can_mb0_claim,
    output logic sram_wr_valid,
    input wire logic sram_wr_ready,
    output logic [31:0] sram_wr_addr,
    output logic [63:0] sram_wr_data,
    output logic [7:0] sram_wr_ecc,
    output logic wdt_enable,
    output logic wdt_refresh,
    output logic jump_valid,
    output logic [31:0] jump_addr,
    output logic variable_length_encoding_flag
);

    sram_word_if word_bus ();

    state_type state_reg, state_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [63:0] pw_reg, pw_next;
    logic [31:0] addr_reg, addr_next;
    logic [31:0] size_reg, size_next;
    logic [30:0] remain_reg, remain_next;
    logic [31:0] waddr_reg, waddr_next;
    logic [63:0] word_reg, word_next;
    logic [2:0] idx_reg, idx_next;
    logic full_reg, full_next;
    logic [63:0] frame_reg, frame_next;
    logic [3:0] left_reg, left_next;
    logic uecho_reg, uecho_next;
    logic [7:0] udata_reg, udata_next;
    logic cecho_reg, cecho_next;
    logic [63:0] cdata_reg, cdata_next;
    logic [3:0] clen_reg, clen_next;
    logic refresh_reg, refresh_next;
    logic enc_flag_reg, enc_flag_next;
    logic stream_state, uart_take, can_take, byte_valid, pw_match, write_done;
    logic [7:0] rx_byte;
    logic [31:0] shifted;

    // A stored password is usable only if no halfword is all zeros or all ones.
    function automatic logic flash_pw_ok(input logic [63:0] p);
        logic ok;
        ok = 1'b1;
        for (int h = 0; h < 4; h++) begin
            if (p[h*16 +: 16] == `HALF_ALL_ZERO || p[h*16 +: 16] == `HALF_ALL_ONES) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Byte source selection. A new byte or frame is refused while the previous
    // echo is still out, so a host that ignores the echo pacing loses data.
    assign stream_state = (state_reg == ST_PASSWORD) || (state_reg == ST_ADDRESS) ||
                          (state_reg == ST_SIZE) || (state_reg == ST_DATA);
    assign uart_take = !boot_over_can && uart_rx_valid && !uecho_reg && !full_reg &&
                       (stream_state || state_reg == ST_LOCKED);
    assign can_take = boot_over_can && can_rx_valid && !cecho_reg && left_reg == `FRAME_EMPTY &&
                      (stream_state || state_reg == ST_LOCKED);
    assign byte_valid = boot_over_can ? (left_reg != `FRAME_EMPTY && stream_state && !full_reg)
                                      : (uart_take && stream_state);
    assign rx_byte = boot_over_can ? frame_reg[63:56] : uart_rx_data;
    assign pw_match = public_password_select ? (pw_reg == `PUBLIC_PASSWORD)
                    : (flash_pw_ok(flash_password) && pw_reg == flash_password);
    assign write_done = full_reg && word_bus.ready;

    ////////////////////////////////////////////////////////////////////////////
    // Echo logic. Bytes and frames are echoed in the password, address, size and data states, so
    // password traffic always returns and the address only after acceptance.
    always_comb begin
        uecho_next = uecho_reg;
        udata_next = udata_reg;
        cecho_next = cecho_reg;
        cdata_next = cdata_reg;
        clen_next = clen_reg;
        frame_next = frame_reg;
        left_next = left_reg;
        if (uecho_reg && uart_tx_ready) begin
            uecho_next = 1'b0;
        end
        if (uart_take && state_reg != ST_LOCKED) begin
            uecho_next = 1'b1;
            udata_next = uart_rx_data;
        end
        if (cecho_reg && can_tx_ready) begin
            cecho_next = 1'b0;
        end
        if (byte_valid && boot_over_can) begin
            frame_next = {frame_reg[55:0], 8'h00};
            left_next = left_reg - 4'h1;
        end
        if (state_reg == ST_DONE || state_reg == ST_LOCKED) begin
            left_next = `FRAME_EMPTY; // Trailing bytes past the image are dropped.
        end
        if (can_take && state_reg != ST_LOCKED) begin
            cecho_next = 1'b1;
            cdata_next = can_rx_data;
            clen_next = can_rx_len;
            frame_next = can_rx_data;
            left_next = can_rx_len;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n || wdt_timeout) begin
            uecho_reg <= 1'b0;
            udata_reg <= 8'h00;
            cecho_reg <= 1'b0;
            cdata_reg <= 64'h0000_0000_0000_0000;
            clen_reg <= 4'h0;
            frame_reg <= 64'h0000_0000_0000_0000;
            left_reg <= 4'h0;
        end else begin
            uecho_reg <= uecho_next;
            udata_reg <= udata_next;
            cecho_reg <= cecho_next;
            cdata_reg <= cdata_next;
            clen_reg <= clen_next;
            frame_reg <= frame_next;
            left_reg <= left_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Download sequence: fields in fixed order, most significant byte first.
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        pw_next = pw_reg;
        addr_next = addr_reg;
        size_next = size_reg;
        remain_next = remain_reg;
        waddr_next = waddr_reg;
        word_next = word_reg;
        idx_next = idx_reg;
        full_next = full_reg;
        refresh_next = 1'b0;
        enc_flag_next = enc_flag_reg;
        shifted = {size_reg[23:0], rx_byte};
        case (state_reg)
            ST_PASSWORD: begin
                if (byte_valid) begin
                    pw_next = {pw_reg[55:0], rx_byte};
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == `PASSWORD_LAST_BYTE) begin
                        state_next = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                // The copy is wiped here whatever the outcome.
                pw_next = 64'h0000_0000_0000_0000;
                cnt_next = 3'h0;
                if (pw_match) begin
                    state_next = ST_ADDRESS;
                    refresh_next = 1'b1;
                end else begin
                    state_next = ST_LOCKED;
                end
            end
            ST_ADDRESS: begin
                if (byte_valid) begin
                    addr_next = {addr_reg[23:0], rx_byte};
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == `ADDRESS_LAST_BYTE) begin
                        cnt_next = 3'h0;
                        state_next = ST_SIZE;
                    end
                end
            end
            ST_SIZE: begin
                if (byte_valid) begin
                    size_next = shifted;
                    cnt_next = cnt_reg + 3'h1;
                    if (cnt_reg == `SIZE_LAST_BYTE) begin
                        cnt_next = 3'h0;
                        enc_flag_next = shifted[`ENC_FLAG_BIT];
                        remain_next = shifted[30:0];
                        waddr_next = addr_reg;
                        state_next = (shifted[30:0] == 31'h0000_0000) ? ST_DONE : ST_DATA;
                    end
                end
            end
            ST_DATA: begin
                if (write_done) begin
                    full_next = 1'b0;
                    word_next = 64'h0000_0000_0000_0000;
                    idx_next = 3'h0;
                    waddr_next = waddr_reg + `WORD_STEP;
                    refresh_next = 1'b1;
                    if (remain_reg == 31'h0000_0000) begin
                        state_next = ST_DONE;
                    end
                end else if (byte_valid) begin
                    // A short final group is padded with zeros.
                    word_next[{~idx_reg, 3'b000} +: 8] = rx_byte;
                    idx_next = idx_reg + 3'h1;
                    remain_next = remain_reg - 31'h0000_0001;
                    if (idx_reg == `WORD_LAST_BYTE || remain_reg == 31'h0000_0001) begin
                        full_next = 1'b1;
                    end
                end
            end
            ST_DONE: begin
                state_next = ST_DONE;
            end
            ST_LOCKED: begin
                state_next = ST_LOCKED;
            end
            default: begin
                state_next = ST_PASSWORD;
            end
        endcase
    end

    // The watchdog timeout restarts the sequence as a reset does, but the SRAM write port keeps any word it holds.
    always_ff @(posedge clk_sys) begin
        if (!reset_n || wdt_timeout) begin
            state_reg <= ST_PASSWORD;
            cnt_reg <= 3'h0;
            pw_reg <= 64'h0000_0000_0000_0000;
            addr_reg <= 32'h0000_0000;
            size_reg <= 32'h0000_0000;
            remain_reg <= 31'h0000_0000;
            waddr_reg <= 32'h0000_0000;
            word_reg <= 64'h0000_0000_0000_0000;
            idx_reg <= 3'h0;
            full_reg <= 1'b0;
            refresh_reg <= 1'b0;
            enc_flag_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            pw_reg <= pw_next;
            addr_reg <= addr_next;
            size_reg <= size_next;
            remain_reg <= remain_next;
            waddr_reg <= waddr_next;
            word_reg <= word_next;
            idx_reg <= idx_next;
            full_reg <= full_next;
            refresh_reg <= refresh_next;
            enc_flag_reg <= enc_flag_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // SRAM write port and outputs.
    assign word_bus.valid = full_reg;
    assign word_bus.addr = waddr_reg;
    assign word_bus.data = word_reg;

    sram_write_port u_write_port (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .word_in(word_bus),
        .sram_wr_valid(sram_wr_valid),
        .sram_wr_ready(sram_wr_ready),
        .sram_wr_addr(sram_wr_addr),
        .sram_wr_data(sram_wr_data),
        .sram_wr_ecc(sram_wr_ecc)
    );

    assign uart_tx_valid = uecho_reg;
    assign uart_tx_data = udata_reg;
    assign can_tx_valid = cecho_reg;
    assign can_tx_data = cdata_reg;
    assign can_tx_len = clen_reg;
    assign can_mb0_claim = boot_over_can && state_reg != ST_DONE;
    assign wdt_enable = 1'b1;
    assign wdt_refresh = refresh_reg;
    assign jump_valid = state_reg == ST_DONE;
    assign jump_addr = addr_reg;
    assign variable_length_encoding_flag = enc_flag_reg;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n || wdt_timeout);

    pw_echo_a: assert property (
        state_reg == ST_PASSWORD && uart_take |=> uart_tx_valid && uart_tx_data == $past(uart_rx_data))
        else $error("Password byte not echoed");
    locked_silent_a: assert property (
        state_reg == ST_LOCKED && (uart_take || can_take) |=> !$rose(uart_tx_valid) && !$rose(can_tx_valid))
        else $error("Echo produced after rejection");
    locked_stays_a: assert property (
        state_reg == ST_LOCKED |=> state_reg == ST_LOCKED)
        else $error("Locked state left without restart");
    check_refresh_a: assert property (
        state_reg == ST_CHECK && pw_match |=> wdt_refresh && state_reg == ST_ADDRESS)
        else $error("No refresh on password acceptance");
    write_refresh_a: assert property (
        full_reg && word_bus.ready |=> wdt_refresh && sram_wr_valid)
        else $error("No refresh after SRAM write");
    pw_wiped_a: assert property (
        state_reg == ST_CHECK |=> pw_reg == 64'h0000_0000_0000_0000)
        else $error("Password copy survives comparison");
    public_pw_a: assert property (
        state_reg == ST_CHECK && public_password_select && pw_reg != `PUBLIC_PASSWORD
        |=> state_reg == ST_LOCKED)
        else $error("Wrong public password accepted");
    bad_flash_a: assert property (
        state_reg == ST_CHECK && !public_password_select && !flash_pw_ok(flash_password)
        |=> state_reg == ST_LOCKED)
        else $error("Invalid flash password accepted");
    jump_end_a: assert property (
        $rose(jump_valid) |-> remain_reg == 31'h0000_0000 && !full_reg && !can_mb0_claim)
        else $error("Handover before image complete");
    pack_full_a: assert property (
        state_reg == ST_DATA && byte_valid && idx_reg == 3'h7 |=> full_reg)
        else $error("Eight bytes did not form a write");

endmodule

`default_nettype wire

// File: sram_sink_model.sv
// Behavioural SRAM write sink that stalls the engine at random.
`timescale 1ns/1ps
`default_nettype none

module sram_sink_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic sram_wr_valid,
    output logic sram_wr_ready,
    output logic took
);
    // Ready wanders so that the engine must hold each write until it lands.
    always @(negedge clk_sys) begin
        sram_wr_ready <= reset_n && (($urandom % 3) == 0);
    end

    // One 64-bit write is stored on each edge where valid meets ready.
    assign took = sram_wr_valid & sram_wr_ready;
endmodule

`default_nettype wire

// File: serial_boot_download_tb.sv
// Self-checking bench for the serial boot download engine.
`timescale 1ns/1ps
`default_nettype none
`include "serial_boot_consts.svh"

module serial_boot_download_tb;
    logic clk_sys = 1'b0, reset_n = 1'b0, boot_over_can = 1'b0, public_password_select = 1'b0;
    logic [63:0] flash_password = '0, can_rx_data = '0, can_tx_data, sram_wr_data;
    logic wdt_timeout = 1'b0, uart_rx_valid = 1'b0, uart_tx_ready = 1'b0, can_rx_valid = 1'b0;
    logic [7:0] uart_rx_data = '0, uart_tx_data, sram_wr_ecc;
    logic [3:0] can_rx_len = '0, can_tx_len;
    logic can_tx_ready = 1'b0, uart_tx_valid, can_tx_valid, can_mb0_claim, sram_wr_valid;
    logic sram_wr_ready, wdt_enable, wdt_refresh, jump_valid, variable_length_encoding_flag;
    logic took;
    logic [63:0] w_exp;
    logic [31:0] sram_wr_addr, jump_addr;
    int num_errors = 0, comparisons = 0, refreshes = 0, seed;
    logic [7:0] bytes[$];
    logic [31:0] exp_a[$];
    logic [63:0] exp_d[$];

    serial_boot_download serial_boot_download_i (.*);
    sram_sink_model sram_sink_model_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .sram_wr_valid(sram_wr_valid), .sram_wr_ready(sram_wr_ready), .took(took));

    // The clock runs at 40 MHz.
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Reference check bits: six positional parities, overall parity, even-bit parity.
    function automatic logic [7:0] ecc_model(input logic [63:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int j = 0; j < 64; j++) begin
            for (int i = 0; i < 6; i++)
                c[i] ^= d[j] & j[i];
            c[6] ^= d[j];
            c[7] ^= d[j] & ~j[0];
        end
        return c;
    endfunction

    // Every write taken by the sink is compared with the model's next word.
    always @(posedge clk_sys) begin
        if (wdt_refresh === 1'b1)
            refreshes++;
        if (took === 1'b1) begin
            check("sram_count", 1, exp_a.size() > 0);
            if (exp_a.size() > 0) begin
                w_exp = exp_d.pop_front();
                check("sram_addr", exp_a.pop_front(), sram_wr_addr);
                check("sram_data", w_exp, sram_wr_data);
                check("sram_ecc", ecc_model(w_exp), sram_wr_ecc);
            end
        end
    end

    task automatic do_reset;
        @(negedge clk_sys);
        reset_n = 1'b0;
        repeat (8) @(negedge clk_sys);
        reset_n = 1'b1;
    endtask

    // Offers one byte or frame and holds it until the echo shows or the bound runs out.
    task automatic put(input logic [63:0] f, input int len, input bit echo);
        int n;
        logic [63:0] m;
        m = ~64'h0 << (64 - 8 * len);
        @(negedge clk_sys);
        can_rx_valid = boot_over_can;
        can_rx_data = f;
        can_rx_len = len[3:0];
        uart_rx_valid = !boot_over_can;
        uart_rx_data = f[63:56];
        n = 0;
        while (uart_tx_valid !== 1'b1 && can_tx_valid !== 1'b1 && n < (echo ? 200 : 12)) begin
            @(negedge clk_sys);
            n++;
        end
        uart_rx_valid = 1'b0;
        can_rx_valid = 1'b0;
        check("echo_seen", echo, uart_tx_valid | can_tx_valid);
        if (echo && n >= 200)
            end_sim();
        if (echo && boot_over_can) begin
            check("can_echo", f & m, can_tx_data & m);
            check("can_echo_len", len, can_tx_len);
        end else if (echo) begin
            check("uart_echo", f[63:56], uart_tx_data);
        end
        // The host waits out each echo before offering the next unit.
        repeat ($urandom % 4) @(negedge clk_sys);
        uart_tx_ready = 1'b1;
        can_tx_ready = 1'b1;
        @(negedge clk_sys);
        uart_tx_ready = 1'b0;
        can_tx_ready = 1'b0;
    endtask

    // Sends password, address, size word and image, building the expected writes.
    task automatic run(input bit can, input bit sel, input logic [63:0] flash,
            input logic [63:0] pw, input bit ok, input int nb, input bit encf);
        logic [31:0] addr, size;
        logic [63:0] w, f;
        int i, k, sent, r0, words;
        boot_over_can = can;
        public_password_select = sel;
        flash_password = flash;
        do_reset();
        check("claim_idle", can, can_mb0_claim);
        check("wdt_enable", 1, wdt_enable);
        addr = $urandom & 32'hFFFF_FFF8;
        size = {encf, nb[30:0]};
        bytes.delete();
        w = '0;
        words = 0;
        for (i = 0; i < 8; i++)
            bytes.push_back(pw[63 - 8 * i -: 8]);
        for (i = 0; i < 8; i++)
            bytes.push_back(i < 4 ? addr[31 - 8 * i -: 8] : size[63 - 8 * i -: 8]);
        for (i = 0; i < nb; i++) begin
            bytes.push_back($urandom);
            w[63 - 8 * (i % 8) -: 8] = bytes[16 + i];
            if (i % 8 == 7 || i == nb - 1) begin
                exp_a.push_back(ok ? addr + 8 * (i / 8) : 32'h0);
                exp_d.push_back(w);
                w = '0;
                words++;
            end
        end
        if (!ok) begin
            exp_a.delete();
            exp_d.delete();
        end
        r0 = refreshes;
        sent = 0;
        while (bytes.size() > 0 && (ok || sent < 24)) begin
            k = can ? (bytes.size() < 8 ? bytes.size() : 8) : 1;
            f = {$urandom, $urandom};
            for (i = 0; i < k; i++)
                f[63 - 8 * i -: 8] = bytes.pop_front();
            put(f, k, ok || sent < 8);
            sent += k;
        end
        if (ok) begin
            i = 0;
            // Wait for the handover and for the sink to take the last word, so the
            // final refresh pulse has been counted as well.
            while ((jump_valid !== 1'b1 || exp_a.size() > 0) && i < 300) begin
                @(negedge clk_sys);
                i++;
            end
            check("jump_valid", 1, jump_valid);
            check("jump_addr", addr, jump_addr);
            check("jump_flag", encf, variable_length_encoding_flag);
            check("claim_free", 0, can_mb0_claim);
            check("refreshes", 1 + words, refreshes - r0);
            check("sram_left", 0, exp_a.size());
            if (i >= 300)
                end_sim();
        end else begin
            check("no_refresh", r0, refreshes);
        end
        $display("test can=%0d public=%0d accept=%0d bytes=%0d done", can, sel, ok, nb);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #2500000;
        num_errors++;
        end_sim();
    end

    // Main sequence: serial and CAN, public and flash passwords, short and exact groups.
    initial begin
        seed = $urandom(47);
        run(0, 1, 64'h0, `PUBLIC_PASSWORD, 1, 13, 1);
        run(0, 1, 64'h0, `PUBLIC_PASSWORD ^ 64'h1, 0, 0, 0);
        // A watchdog expiry reopens the sequence after a rejection.
        @(negedge clk_sys);
        wdt_timeout = 1'b1;
        @(negedge clk_sys);
        wdt_timeout = 1'b0;
        put({`PUBLIC_PASSWORD}, 1, 1);
        run(0, 0, 64'h1234_FFFF_5678_9ABC, 64'h1234_FFFF_5678_9ABC, 0, 0, 0);
        run(1, 0, 64'h0000_1111_2222_3333, 64'h0000_1111_2222_3333, 0, 0, 0);
        run(1, 0, 64'h1234_5678_9ABC_DEF1, 64'h1234_5678_9ABC_DEF1, 1, 20, 0);
        run(1, 1, 64'h0, `PUBLIC_PASSWORD, 1, 16, 1);
        run(0, 0, 64'h1234_5678_9ABC_DEF1, 64'h1234_5678_9ABC_DEF1, 1, 0, 1);
        end_sim();
    end
endmodule

`default_nettype wire
